// ==== hdl/spl_pkg.sv ====
// Constants shared by the serial program loader and its page buffer.
// Assumes a 125 MHz system clock and byte-wide nonvolatile storage ports.
package spl_pkg;

   // ==========================================================
   // Clock and write delays
   localparam int SPL_CLK_NS = 8;
   localparam int SPL_FLASH_DLY_NS = 5000000;
   localparam int SPL_EE_DLY_NS = 5000000;
   localparam int SPL_FLASH_DLY_CYC =
      (SPL_FLASH_DLY_NS + SPL_CLK_NS - 1) / SPL_CLK_NS;
   localparam int SPL_EE_DLY_CYC =
      (SPL_EE_DLY_NS + SPL_CLK_NS - 1) / SPL_CLK_NS;
   localparam int SPL_WAIT_W = 20;

   // ==========================================================
   // Frame layout
   localparam int SPL_FRAME_BITS = 32;
   localparam logic [5:0] SPL_LAST_BIT = 6'h1F;
   localparam logic [5:0] SPL_MID_BIT = 6'h17;
   localparam logic [2:0] SPL_BYTE_END = 3'h7;
   localparam int SPL_FL_LSB_W = 5;
   localparam int SPL_PAGE_W = 6;
   localparam int SPL_EE_LSB_W = 2;
   localparam int SPL_FL_BUF_DEPTH = 64;
   localparam int SPL_EE_BUF_DEPTH = 4;
   localparam logic [5:0] SPL_FL_LAST_IDX = 6'h3F;
   localparam logic [5:0] SPL_EE_LAST_IDX = 6'h03;
   localparam logic [7:0] SPL_OUT_RST = 8'h00;

   // ==========================================================
   // Instruction opcodes, first byte of a frame; enable key, second byte
   localparam logic [7:0] SPL_OP_PROG_EN = 8'hAC;
   localparam logic [7:0] SPL_PROG_EN_KEY = 8'h53;
   localparam logic [7:0] SPL_OP_LD_FL_LO = 8'h40;
   localparam logic [7:0] SPL_OP_LD_FL_HI = 8'h48;
   localparam logic [7:0] SPL_OP_WR_FL_PG = 8'h4C;
   localparam logic [7:0] SPL_OP_RD_FL_LO = 8'h20;
   localparam logic [7:0] SPL_OP_RD_FL_HI = 8'h28;
   localparam logic [7:0] SPL_OP_WR_EE_B = 8'hC0;
   localparam logic [7:0] SPL_OP_LD_EE = 8'hC1;
   localparam logic [7:0] SPL_OP_WR_EE_PG = 8'hC2;
   localparam logic [7:0] SPL_OP_RD_EE = 8'hA0;
   localparam logic [7:0] SPL_OP_POLL = 8'hF0;

   typedef enum logic [2:0] {
      SPL_ST_IDLE,
      SPL_ST_FL_RD,
      SPL_ST_FL_WR,
      SPL_ST_EE_ERASE,
      SPL_ST_EE_WR,
      SPL_ST_EE_PG,
      SPL_ST_WAIT
   } spl_state_e;

endpackage

// ==== hdl/spl_mem.sv ====
// Small dual-port byte memory used as the program page buffer.
// Assumes one write and one read port on the same clock; read data is
// registered, so it is valid one cycle after the read address.
`timescale 1ns/10ps

module spl_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem [DEPTH];

   // ==========================================================
   // Storage has no reset; only the read register is cleared.
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end

endmodule

// ==== hdl/spl_loader.sv ====
// Serial in-system program loader: a four-byte instruction slave that
// fills page buffers and commits them to the nonvolatile store.
// Assumes sck, mosi and target_reset_n come from the external programmer
// and the store answers a read with nvm_rdata one cycle after nvm_rd.
`timescale 1ns/10ps

module spl_loader import spl_pkg::*; #(
   parameter int FLASH_DLY_CYC = SPL_FLASH_DLY_CYC,
   parameter int EE_DLY_CYC = SPL_EE_DLY_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic sck,
   input wire logic mosi,
   input wire logic target_reset_n,
   output logic miso_out,
   output logic miso_oe,
   output logic cpu_run,
   output logic prog_enabled,
   output logic busy,
   output logic nvm_rd,
   output logic nvm_wr,
   output logic nvm_erase,
   output logic nvm_eeprom,
   output logic [11:0] nvm_addr,
   output logic [7:0] nvm_wdata,
   input wire logic [7:0] nvm_rdata
);

   // ==========================================================
   // Pin synchronisers and serial clock edges
   logic sck_s1_reg, sck_s2_reg, sck_d_reg;
   logic mosi_s1_reg, mosi_s2_reg;
   logic rst_s1_reg, rst_s2_reg;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sck_s1_reg <= 1'b0;
         sck_s2_reg <= 1'b0;
         sck_d_reg <= 1'b0;
         mosi_s1_reg <= 1'b0;
         mosi_s2_reg <= 1'b0;
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= 1'b1;
      end else begin
         sck_s1_reg <= sck;
         sck_s2_reg <= sck_s1_reg;
         sck_d_reg <= sck_s2_reg;
         mosi_s1_reg <= mosi;
         mosi_s2_reg <= mosi_s1_reg;
         rst_s1_reg <= target_reset_n;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   wire prog_mode = !rst_s2_reg;
   wire sck_rise = prog_mode && sck_s2_reg && !sck_d_reg;
   wire sck_fall = prog_mode && !sck_s2_reg && sck_d_reg;

   assign cpu_run = rst_s2_reg;
   assign miso_oe = prog_mode;

   // ==========================================================
   // Receive shifter and frame counter
   logic [SPL_FRAME_BITS-1:0] shift_reg;
   logic [5:0] cnt_reg;
   logic done_reg, mid_reg;

   wire [SPL_FRAME_BITS-1:0] shift_next = {shift_reg[30:0], mosi_s2_reg};

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         shift_reg <= '0;
         cnt_reg <= 6'h00;
         done_reg <= 1'b0;
         mid_reg <= 1'b0;
      end else begin
         done_reg <= sck_rise && (cnt_reg == SPL_LAST_BIT);
         mid_reg <= sck_rise && (cnt_reg == SPL_MID_BIT);
         if (!prog_mode) begin
            cnt_reg <= 6'h00;
         end else if (sck_rise) begin
            shift_reg <= shift_next;
            cnt_reg <= (cnt_reg == SPL_LAST_BIT) ? 6'h00 : cnt_reg + 6'h01;
         end
      end
   end

   wire [7:0] op = shift_reg[31:24];
   wire [7:0] a_hi = shift_reg[23:16];
   wire [7:0] a_lo = shift_reg[15:8];
   wire [7:0] dat = shift_reg[7:0];
   wire [7:0] mid_op = shift_reg[23:16];
   wire [7:0] mid_ahi = shift_reg[15:8];
   wire [7:0] mid_alo = shift_reg[7:0];

   // ==========================================================
   // Programming enable
   logic prog_en_reg;
   spl_state_e state_reg, state_next;

   assign prog_enabled = prog_en_reg;
   assign busy = (state_reg != SPL_ST_IDLE);

   // act only on a whole frame
   wire cmd_go = done_reg && prog_en_reg && !busy;
   wire en_frame = done_reg && (op == SPL_OP_PROG_EN)
      && (a_hi == SPL_PROG_EN_KEY);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prog_en_reg <= 1'b0;
      end else if (!prog_mode) begin
         prog_en_reg <= 1'b0;
      end else if (en_frame) begin
         prog_en_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Transmit path
   logic [7:0] nxt_out_reg, out_sh_reg;
   logic rd_pend_reg;

   wire mid_rd_fl = (mid_op == SPL_OP_RD_FL_LO) || (mid_op == SPL_OP_RD_FL_HI);
   wire mid_rd_ee = (mid_op == SPL_OP_RD_EE);
   wire mid_poll = mid_reg && prog_en_reg && (mid_op == SPL_OP_POLL);
   wire rd_go = mid_reg && prog_en_reg && !busy && (mid_rd_fl || mid_rd_ee);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         nxt_out_reg <= SPL_OUT_RST;
         out_sh_reg <= SPL_OUT_RST;
         rd_pend_reg <= 1'b0;
      end else begin
         rd_pend_reg <= nvm_rd;
         if (rd_pend_reg) begin
            nxt_out_reg <= nvm_rdata;
         end else if (mid_poll) begin
            nxt_out_reg <= {7'h00, busy};
         end else if (sck_rise && (cnt_reg[2:0] == SPL_BYTE_END)) begin
            nxt_out_reg <= shift_next[7:0];
         end
         if (sck_fall) begin
            if (cnt_reg[2:0] == 3'h0) begin
               out_sh_reg <= nxt_out_reg;
            end else begin
               out_sh_reg <= {out_sh_reg[6:0], 1'b0};
            end
         end
      end
   end

   assign miso_out = out_sh_reg[7];

   // ==========================================================
   // Page buffers
   logic [7:0] fl_rdata;
   logic [5:0] idx_reg, idx_next;
   logic [SPL_PAGE_W-1:0] page_reg, page_next;
   logic [7:0] ee_buf_reg [SPL_EE_BUF_DEPTH];
   logic [SPL_EE_BUF_DEPTH-1:0] ee_vld_reg;
   logic ee_clr;

   // load by five low word bits
   wire fl_ld = cmd_go
      && ((op == SPL_OP_LD_FL_LO) || (op == SPL_OP_LD_FL_HI));
   wire [5:0] fl_waddr = {a_lo[SPL_FL_LSB_W-1:0], op == SPL_OP_LD_FL_HI};
   wire ee_ld = cmd_go && (op == SPL_OP_LD_EE);
   wire [1:0] ee_waddr = a_lo[SPL_EE_LSB_W-1:0];

   spl_mem #(
      .WIDTH(8),
      .DEPTH(SPL_FL_BUF_DEPTH),
      .AW(6)
   ) u_fl_buf (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .we(fl_ld),
      .waddr(fl_waddr),
      .wdata(dat),
      .raddr(idx_reg),
      .rdata(fl_rdata)
   );

   for (genvar i = 0; i < SPL_EE_BUF_DEPTH; i++) begin : g_ee
      always_ff @(posedge clk_sys or negedge nrst) begin
         if (!nrst) begin
            ee_buf_reg[i] <= 8'h00;
            ee_vld_reg[i] <= 1'b0;
         end else if (ee_ld && (ee_waddr == 2'(i))) begin
            ee_buf_reg[i] <= dat;
            ee_vld_reg[i] <= 1'b1;
         end else if (ee_clr) begin
            ee_vld_reg[i] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Commit sequencer
   logic [SPL_WAIT_W-1:0] wait_reg, wait_next;
   logic nvm_rd_next, nvm_wr_next, nvm_erase_next, nvm_eeprom_next;
   logic [11:0] nvm_addr_next;
   logic [7:0] nvm_wdata_next;

   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      page_next = page_reg;
      wait_next = wait_reg;
      nvm_rd_next = 1'b0;
      nvm_wr_next = 1'b0;
      nvm_erase_next = 1'b0;
      nvm_eeprom_next = nvm_eeprom;
      nvm_addr_next = nvm_addr;
      nvm_wdata_next = nvm_wdata;
      ee_clr = 1'b0;
      case (state_reg)
         SPL_ST_IDLE: begin
            if (rd_go) begin
               nvm_rd_next = 1'b1;
               nvm_eeprom_next = mid_rd_ee;
               nvm_addr_next = mid_rd_ee ? {4'h0, mid_alo}
                  : {mid_ahi[2:0], mid_alo, mid_op == SPL_OP_RD_FL_HI};
            end
            if (cmd_go) begin
               case (op)
                  SPL_OP_WR_FL_PG: begin
                     page_next = {a_hi[2:0], a_lo[7:5]};
                     idx_next = 6'h00;
                     state_next = SPL_ST_FL_RD;
                  end
                  SPL_OP_WR_EE_B: begin
                     nvm_eeprom_next = 1'b1;
                     nvm_addr_next = {4'h0, a_lo};
                     nvm_wdata_next = dat;
                     state_next = SPL_ST_EE_ERASE;
                  end
                  SPL_OP_WR_EE_PG: begin
                     page_next = a_lo[7:2];
                     idx_next = 6'h00;
                     state_next = SPL_ST_EE_PG;
                  end
                  default: begin
                     state_next = SPL_ST_IDLE;
                  end
               endcase
            end
         end
         SPL_ST_FL_RD: begin
            state_next = SPL_ST_FL_WR;
         end
         SPL_ST_FL_WR: begin
            nvm_wr_next = 1'b1;
            nvm_eeprom_next = 1'b0;
            nvm_addr_next = {page_reg, idx_reg};
            nvm_wdata_next = fl_rdata;
            if (idx_reg == SPL_FL_LAST_IDX) begin
               wait_next = SPL_WAIT_W'(FLASH_DLY_CYC);
               state_next = SPL_ST_WAIT;
            end else begin
               idx_next = idx_reg + 6'h01;
               state_next = SPL_ST_FL_RD;
            end
         end
         SPL_ST_EE_ERASE: begin
            nvm_erase_next = 1'b1;
            state_next = SPL_ST_EE_WR;
         end
         SPL_ST_EE_WR: begin
            nvm_wr_next = 1'b1;
            wait_next = SPL_WAIT_W'(EE_DLY_CYC);
            state_next = SPL_ST_WAIT;
         end
         SPL_ST_EE_PG: begin
            nvm_wr_next = ee_vld_reg[idx_reg[1:0]];
            nvm_eeprom_next = 1'b1;
            nvm_addr_next = {4'h0, page_reg, idx_reg[1:0]};
            nvm_wdata_next = ee_buf_reg[idx_reg[1:0]];
            if (idx_reg == SPL_EE_LAST_IDX) begin
               ee_clr = 1'b1;
               wait_next = SPL_WAIT_W'(EE_DLY_CYC);
               state_next = SPL_ST_WAIT;
            end else begin
               idx_next = idx_reg + 6'h01;
            end
         end
         SPL_ST_WAIT: begin
            if (wait_reg == '0) begin
               state_next = SPL_ST_IDLE;
            end else begin
               wait_next = wait_reg - SPL_WAIT_W'(1);
            end
         end
         default: begin
            state_next = SPL_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_reg <= SPL_ST_IDLE;
         idx_reg <= 6'h00;
         page_reg <= '0;
         wait_reg <= '0;
         nvm_rd <= 1'b0;
         nvm_wr <= 1'b0;
         nvm_erase <= 1'b0;
         nvm_eeprom <= 1'b0;
         nvm_addr <= 12'h000;
         nvm_wdata <= 8'h00;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         page_reg <= page_next;
         wait_reg <= wait_next;
         nvm_rd <= nvm_rd_next;
         nvm_wr <= nvm_wr_next;
         nvm_erase <= nvm_erase_next;
         nvm_eeprom <= nvm_eeprom_next;
         nvm_addr <= nvm_addr_next;
         nvm_wdata <= nvm_wdata_next;
      end
   end

endmodule

// ==== testbench/spl_loader_props.sv ====
// Assertions on the loader's top ports, attached by bind.
// Assumes sck is the raw programmer clock, sampled here by clk_sys.
`timescale 1ns/10ps
module spl_loader_props import spl_pkg::*; #(
   parameter int FLASH_DLY_CYC = SPL_FLASH_DLY_CYC,
   parameter int EE_DLY_CYC = SPL_EE_DLY_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic sck,
   input wire logic target_reset_n,
   input wire logic miso_out,
   input wire logic miso_oe,
   input wire logic cpu_run,
   input wire logic prog_enabled,
   input wire logic busy,
   input wire logic nvm_rd,
   input wire logic nvm_wr,
   input wire logic nvm_erase,
   input wire logic nvm_eeprom,
   input wire logic [11:0] nvm_addr
);
   // ==========================================================
   // Age in cycles of the last serial clock edge, saturating
   logic sck_q_reg;
   logic [3:0] rise_age_reg;
   logic [3:0] fall_age_reg;
   logic [3:0] rise_age_next;
   logic [3:0] fall_age_next;
   assign rise_age_next = (sck && !sck_q_reg) ? 4'h0 :
      rise_age_reg + {3'h0, ~&rise_age_reg};
   assign fall_age_next = (!sck && sck_q_reg) ? 4'h0 :
      fall_age_reg + {3'h0, ~&fall_age_reg};
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sck_q_reg <= 1'b0;
         rise_age_reg <= 4'hF;
         fall_age_reg <= 4'hF;
      end else begin
         sck_q_reg <= sck;
         rise_age_reg <= rise_age_next;
         fall_age_reg <= fall_age_next;
      end
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   sequence s_erase_wr;
      nvm_eeprom ##1 (nvm_wr && $stable(nvm_addr));
   endsequence

   AST_ERASE_FIRST: assert property (nvm_erase |-> s_erase_wr)
      else $error("erase not followed by write at same address");
   AST_ONE_CMD: assert property ($onehot0({nvm_rd, nvm_wr, nvm_erase}))
      else $error("more than one store command in a cycle");
   AST_ERASE_BUSY: assert property (nvm_erase |-> ##[1:3] busy)
      else $error("busy missing after data byte write");
   AST_FLASH_PACE: assert property (nvm_wr && !nvm_eeprom |=> !nvm_wr)
      else $error("program page writes not one every second cycle");
   AST_BUSY_HOLD: assert property ($rose(busy) |-> busy [*8])
      else $error("busy dropped too early");
   AST_RD_IDLE: assert property (nvm_rd |-> !busy)
      else $error("store read issued while busy");
   AST_MISO_FALL: assert property (miso_oe && $past(miso_oe) &&
      $changed(miso_out) |-> fall_age_reg inside {[1:6]})
      else $error("serial output changed away from a clock fall");
   AST_ERASE_RISE: assert property (nvm_erase |->
      rise_age_reg inside {[2:8]})
      else $error("byte write not tied to a serial clock rise");
   AST_EN_AFTER_RISE: assert property ($rose(prog_enabled) |->
      rise_age_reg inside {[1:8]})
      else $error("enable not tied to the last frame bit");
   AST_RELEASE: assert property ($rose(target_reset_n) |->
      ##[1:5] (cpu_run && !prog_enabled && !miso_oe))
      else $error("reset release did not end programming");
endmodule

bind spl_loader spl_loader_props #(.FLASH_DLY_CYC(FLASH_DLY_CYC),
   .EE_DLY_CYC(EE_DLY_CYC)) i_spl_loader_props (.clk_sys(clk_sys),
   .nrst(nrst), .sck(sck), .target_reset_n(target_reset_n),
   .miso_out(miso_out), .miso_oe(miso_oe), .cpu_run(cpu_run),
   .prog_enabled(prog_enabled), .busy(busy), .nvm_rd(nvm_rd),
   .nvm_wr(nvm_wr), .nvm_erase(nvm_erase), .nvm_eeprom(nvm_eeprom),
   .nvm_addr(nvm_addr));

// ==== testbench/spl_prog_model.sv ====
// Behavioural external programmer for the serial pins.
// Assumes the bench calls frame() only while the reset pin is held low,
// and that clk_sys is the loader's own clock.
`timescale 1ns/10ps
module spl_prog_model (
   input wire logic clk_sys,
   output logic sck,
   output logic mosi,
   input wire logic miso_out,
   input wire logic miso_oe
);
   // ==========================================================
   // Frame transfer
   logic miso_pin;
   // The output pin is pulled high whenever the loader lets go of it.
   assign miso_pin = miso_oe ? miso_out : 1'b1;
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
   end
   task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
      // The offset keeps every pin change clear of both clk_sys edges.
      @(negedge clk_sys);
      #1.25;
      for (int i = 31; i >= 0; i--) begin
         mosi = tx[i];
         #62.5 sck = 1'b1;
         rx[i] = miso_pin;
         #62.5 sck = 1'b0;
      end
      mosi = ~mosi;
   endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the serial program loader.
// Assumes the programmer model drives the serial pins and the byte
// store modelled here answers the loader's store port.
`timescale 1ns/10ps
module tb import spl_pkg::*;;
   localparam int DLY = 20;
   logic clk_sys, nrst, target_reset_n, sck, mosi, miso_out, miso_oe;
   logic cpu_run, prog_enabled, busy, nvm_rd, nvm_wr, nvm_erase;
   logic nvm_eeprom;
   logic [11:0] nvm_addr;
   logic [7:0] nvm_wdata, nvm_rdata;
   logic [7:0] mem [8192];
   logic [31:0] rx;
   int err_total, n_checks, n_erase, n_flwr;

   // ==========================================================
   // Clock, store model and instances
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (nvm_erase) begin
         mem[{nvm_eeprom, nvm_addr}] <= 8'hFF;
         n_erase <= n_erase + 1;
      end
      if (nvm_wr) begin
         mem[{nvm_eeprom, nvm_addr}] <= nvm_wdata;
         n_flwr <= n_flwr + (nvm_eeprom ? 0 : 1);
      end
      // Read data is only valid the cycle after the request.
      nvm_rdata <= nvm_rd ? mem[{nvm_eeprom, nvm_addr}] : ~nvm_rdata;
   end
   spl_loader #(.FLASH_DLY_CYC(DLY), .EE_DLY_CYC(DLY)) i_spl_loader (
      .clk_sys(clk_sys), .nrst(nrst), .sck(sck), .mosi(mosi),
      .target_reset_n(target_reset_n), .miso_out(miso_out),
      .miso_oe(miso_oe), .cpu_run(cpu_run), .prog_enabled(prog_enabled),
      .busy(busy), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr),
      .nvm_erase(nvm_erase), .nvm_eeprom(nvm_eeprom),
      .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata));
   spl_prog_model i_spl_prog_model (.clk_sys(clk_sys), .sck(sck),
      .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe));

   // ==========================================================
   // Shared tasks
   task automatic chk_byte(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic xfer(input logic [31:0] tx);
      i_spl_prog_model.frame(tx, rx);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (4) @(negedge clk_sys);
      while (busy !== 1'b0 && n < 4000) begin
         @(negedge clk_sys);
         n++;
      end
      if (busy !== 1'b0) begin
         err_total++;
         $display("Error busy expected 0 seen %b", busy);
         print_verdict();
      end
   endtask
   task automatic set_pin(input logic lvl);
      @(negedge clk_sys);
      target_reset_n = lvl;
      repeat (8) @(negedge clk_sys);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_enable();
      mem[13'h1010] = 8'h00;
      xfer(32'hC0_00_10_77);
      repeat (40) @(negedge clk_sys);
      chk_byte("early write", 8'h00, mem[13'h1010]);
      xfer(32'hAC_53_00_00);
      chk_byte("echo", SPL_PROG_EN_KEY, rx[15:8]);
      chk_byte("enabled", 8'h01, {7'h0, prog_enabled});
      $display("Test enable done");
   endtask
   task automatic t_ee_byte();
      n_erase = 0;
      xfer(32'hC0_00_AA_5A);
      repeat (4) @(negedge clk_sys);
      chk_byte("busy", 8'h01, {7'h0, busy});
      wait_idle();
      chk_byte("erase pulses", 8'h01, 8'(n_erase));
      xfer(32'hF0_00_00_00);
      chk_byte("poll", 8'h00, rx[7:0]);
      xfer(32'hA0_00_AA_00);
      chk_byte("data read", 8'h5A, rx[7:0]);
      $display("Test data byte done");
   endtask
   task automatic t_ee_page();
      for (int i = 0; i < 4; i++)
         mem[13'h1040 + 13'(i)] = 8'hEE;
      xfer(32'hC1_00_41_B1);
      xfer(32'hC1_00_43_B3);
      xfer(32'hC2_00_40_00);
      wait_idle();
      chk_byte("slot 0", 8'hEE, mem[13'h1040]);
      chk_byte("slot 1", 8'hB1, mem[13'h1041]);
      chk_byte("slot 2", 8'hEE, mem[13'h1042]);
      chk_byte("slot 3", 8'hB3, mem[13'h1043]);
      mem[13'h1041] = 8'h00;
      xfer(32'hC2_00_40_00);
      wait_idle();
      chk_byte("recommit", 8'h00, mem[13'h1041]);
      $display("Test data page done");
   endtask
   task automatic t_flash();
      n_flwr = 0;
      xfer(32'h40_00_03_12);
      xfer(32'h48_00_03_34);
      xfer(32'h4C_00_40_00);
      wait_idle();
      chk_byte("page writes", 8'h40, 8'(n_flwr));
      chk_byte("low byte", 8'h12, mem[13'h0086]);
      chk_byte("high byte", 8'h34, mem[13'h0087]);
      xfer(32'h28_00_43_00);
      chk_byte("program read", 8'h34, rx[7:0]);
      xfer(32'h20_00_43_00);
      chk_byte("program low read", 8'h12, rx[7:0]);
      $display("Test program page done");
   endtask
   task automatic t_resync();
      set_pin(1'b1);
      chk_byte("run", 8'h01, {7'h0, cpu_run});
      chk_byte("left mode", 8'h00, {7'h0, prog_enabled});
      set_pin(1'b0);
      xfer(32'hAC_00_00_00);
      chk_byte("bad echo", 8'h00, rx[15:8]);
      chk_byte("not enabled", 8'h00, {7'h0, prog_enabled});
      set_pin(1'b1);
      set_pin(1'b0);
      xfer(32'hAC_53_00_00);
      chk_byte("re-enabled", 8'h01, {7'h0, prog_enabled});
      $display("Test resync done");
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      clk_sys = 1'b0;
      nrst = 1'b0;
      target_reset_n = 1'b0;
      nvm_rdata = 8'h00;
      err_total = 0;
      n_checks = 0;
      n_erase = 0;
      n_flwr = 0;
      repeat (10) @(negedge clk_sys);
      nrst = 1'b1;
      set_pin(1'b1);
      set_pin(1'b0);
      // power-up wait, scaled down so the run stays short.
      repeat (DLY) @(negedge clk_sys);
      t_enable();
      t_ee_byte();
      t_ee_page();
      t_flash();
      t_resync();
      print_verdict();
   end
   initial begin
      #300000;
      err_total++;
      $display("Error watchdog expected done seen hang");
      print_verdict();
   end
endmodule
